// >>> rtl/sbg_defines.svh
/*
 * Constants of the serial baud divider: register offsets, field
 * positions, reset values and prescale counts.
 * Assumes it is included by bare name from the package and modules.
 */
// Overview of operation
// R1 - Eight-bit divider by default, sixteen when enabled
// R2 - Divisor pair sets free-running timer period
// R3 - Divisor is high byte above low byte
// R4 - Narrow mode ignores the high divisor byte
// R5 - Async rate depends on speed and width
// R6 - Async narrow low speed: clock/(64(n+1))
// R7 - Async narrow high speed: clock/(16(n+1))
// R8 - Async wide low speed: clock/(16(n+1))
// R9 - Async wide high speed: clock/(4(n+1))
// R10 - Sync mode ignores speed, clock/(4(n+1))
// R11 - Formulas for master only; slave uses external
// R12 - Sync master drives clock from this divider
// R13 - Divisor write clears running timer immediately
// R14 - Timer runs from the device clock
// R15 - Three receive samples, majority decides level
// R16 - Port disabled holds divider in reset
`ifndef SBG_DEFINES_SVH
`define SBG_DEFINES_SVH

// Register offsets on the plain register port
`define SBG_ADDR_TXCTL 3'h0
`define SBG_ADDR_RXCTL 3'h1
`define SBG_ADDR_BAUDCTL 3'h2
`define SBG_ADDR_DIVHI 3'h3
`define SBG_ADDR_DIVLO 3'h4
`define SBG_ADDR_STATUS 3'h5

// Reset values
`define SBG_RST_TXCTL 8'h00
`define SBG_RST_RXCTL 8'h00
`define SBG_RST_BAUDCTL 8'h00
`define SBG_RST_DIV 8'h00

// Transmit control field positions
`define SBG_TX_CLKSRC 7
`define SBG_TX_SYNC 4
`define SBG_TX_HISPEED 2
`define SBG_TX_SHIFT_EMPTY 1
// Receive control field positions
`define SBG_RX_PORTEN 7
// Baud control field positions
`define SBG_BC_IDLE 6
`define SBG_BC_CLKPOL 4
`define SBG_BC_WIDE 3
// Writable masks; other bits read from hardware or as zero
`define SBG_TXCTL_WMASK 8'hFD
`define SBG_RXCTL_WMASK 8'hF8
`define SBG_BAUDCTL_WMASK 8'h9B

// Prescale terminal counts (half of the factor, minus one)
`define SBG_PRE_DIV64 5'h1F
`define SBG_PRE_DIV16 5'h07
`define SBG_PRE_DIV4 5'h01

// Number of majority samples per bit
`define SBG_NUM_SAMPLES 2'h3

`endif

// >>> rtl/sbg_pkg.sv
/*
 * Types shared by the serial baud divider modules.
 * Assumes the defines header sits beside it on the include path.
 */
`include "sbg_defines.svh"

package sbg_pkg;
    // Register port address
    typedef logic [2:0] sbg_addr_t;
    // Register byte
    typedef logic [7:0] sbg_byte_t;
    // Division factor selected by the mode bits
    typedef enum {
        SBG_FACT64,
        SBG_FACT16,
        SBG_FACT4
    } sbg_factor_t;
endpackage

// >>> rtl/sbg_majority.sv
/*
 * Three-sample majority voter for the receive line.
 * Assumes the line is already synchronised to clk and that the
 * strobe arrives three times per bit.
 */
module sbg_majority (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic lineIn,
    input wire logic strobe,
    output logic bitOut,
    output logic bitValid
);
    import sbg_pkg::*;

    // Whole state of the voter
    typedef struct packed {
        logic [2:0] samp;  // Sample history
        logic [1:0] count; // Samples taken this bit
        logic bitOut;      // Voted level
        logic bitValid;    // Vote completed pulse
    } sbg_maj_t;

    sbg_maj_t st_reg;
    sbg_maj_t st_next;

    // Collect samples and vote on the third
    always_comb begin
        st_next = st_reg;
        st_next.bitValid = 1'b0;
        if (clr) begin
            st_next.count = 2'h0;
        end else if (strobe) begin
            st_next.samp = {st_reg.samp[1:0], lineIn};
            if (st_reg.count == `SBG_NUM_SAMPLES - 2'h1) begin
                // Two of three decide the level
                st_next.bitOut = (st_reg.samp[1] & st_reg.samp[0]) |
                    (st_reg.samp[1] & lineIn) |
                    (st_reg.samp[0] & lineIn); // R15
                st_next.bitValid = 1'b1;
                st_next.count = 2'h0;
            end else begin
                st_next.count = st_reg.count + 2'h1;
            end
        end
    end

    // State register, idle line high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{samp: 3'h7, count: 2'h0, bitOut: 1'b1,
                bitValid: 1'b0};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign bitOut = st_reg.bitOut;
    assign bitValid = st_reg.bitValid;
endmodule

// >>> rtl/sbg_baud_gen.sv
/*
 * Baud divider of the serial port: control registers, the
 * free-running divider timer, serial clock generation and the
 * receive line sampler.
 * Assumes a single device clock, a plain register port driven on
 * the same clock, and pins that arrive asynchronously.
 */
`include "sbg_defines.svh"

module sbg_baud_gen (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire sbg_pkg::sbg_addr_t regAddr,
    input wire sbg_pkg::sbg_byte_t regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output sbg_pkg::sbg_byte_t regRdData,
    input wire logic rxPin,
    input wire logic serClkIn,
    output logic serClkOut,
    output logic serClkOe,
    output logic halfTick,
    output logic baudTick,
    output logic rxBit,
    output logic rxBitValid,
    output logic portEnable
);
    import sbg_pkg::*;

    // Whole state of the divider block
    typedef struct packed {
        sbg_byte_t rdData;  // Read data, one cycle after strobe
        sbg_byte_t txCtl;   // Transmit control register
        sbg_byte_t rxCtl;   // Receive control register
        sbg_byte_t baudCtl; // Baud control register
        sbg_byte_t divHi;   // Divisor high byte
        sbg_byte_t divLo;   // Divisor low byte
        logic [4:0] pre;    // Prescaler count
        logic [15:0] cnt;   // Divider timer count
        logic phase;        // Second half of the bit period
        logic clkLvl;       // Serial clock level before polarity
        logic halfTick;     // Half-period pulse
        logic baudTick;     // Full bit period pulse
        logic rxMeta;       // Receive pin, first stage
        logic rxSync;       // Receive pin, second stage
        logic ckMeta;       // Clock pin, first stage
        logic ckSync;       // Clock pin, second stage
        logic ckDly;        // Clock pin, delayed for edge detect
        logic [1:0] sampLeft; // Majority strobes still to issue
        logic sampStrobe;   // Majority sample strobe
    } sbg_state_t;

    sbg_state_t st_reg;
    sbg_state_t st_next;

    // Decoded mode bits
    logic syncMode;   // Synchronous mode
    logic master;     // Synchronous master
    logic wide;       // Sixteen-bit divider
    logic hiSpeed;    // High speed select
    logic enabled;    // Serial port enable
    logic clkPol;     // Idle level of serial clock
    sbg_factor_t factor; // Selected division factor
    logic [4:0] preTop;  // Prescaler terminal count
    logic [15:0] divisor; // Divisor in use
    logic divWrite;   // Either divisor byte written
    logic preWrap;    // Prescaler at terminal count
    logic cntWrap;    // Divider timer at terminal count
    logic ckEdge;     // Active external clock edge
    logic voteBit;    // Voter level
    logic voteValid;  // Voter completed pulse

    // Mode bits straight from the control registers
    assign syncMode = st_reg.txCtl[`SBG_TX_SYNC];
    assign master = syncMode & st_reg.txCtl[`SBG_TX_CLKSRC];
    assign wide = st_reg.baudCtl[`SBG_BC_WIDE]; // R1
    assign hiSpeed = st_reg.txCtl[`SBG_TX_HISPEED];
    assign enabled = st_reg.rxCtl[`SBG_RX_PORTEN];
    assign clkPol = st_reg.baudCtl[`SBG_BC_CLKPOL];

    // High byte only takes part in wide mode
    assign divisor = wide ? {st_reg.divHi, st_reg.divLo} // R3
        : {8'h00, st_reg.divLo}; // R4

    // Factor selection from sync, width and speed bits
    always_comb begin
        if (syncMode) begin
            // Speed select has no effect here
            factor = SBG_FACT4; // R10
        end else if (!wide && !hiSpeed) begin
            factor = SBG_FACT64; // R5 R6
        end else if (!wide && hiSpeed) begin
            factor = SBG_FACT16; // R7
        end else if (wide && !hiSpeed) begin
            factor = SBG_FACT16; // R8
        end else begin
            factor = SBG_FACT4; // R9
        end
    end

    // Prescaler runs half the factor, timer toggles twice per bit
    always_comb begin
        unique case (factor)
            SBG_FACT64: preTop = `SBG_PRE_DIV64;
            SBG_FACT16: preTop = `SBG_PRE_DIV16;
            SBG_FACT4: preTop = `SBG_PRE_DIV4;
        endcase
    end

    // Write to either divisor byte restarts the timer
    assign divWrite = regWr && (regAddr == `SBG_ADDR_DIVHI ||
        regAddr == `SBG_ADDR_DIVLO);

    // Wrap conditions; a count above a new smaller divisor wraps too
    assign preWrap = (st_reg.pre >= preTop);
    assign cntWrap = (st_reg.cnt >= divisor);

    // Active edge of the synchronised external clock
    assign ckEdge = (st_reg.ckSync != st_reg.ckDly) &&
        ((st_reg.ckSync ^ clkPol) == 1'b0);

    // Majority voter on the synchronised receive line
    sbg_majority u_majority (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .clr(!enabled),
        .lineIn(st_reg.rxSync),
        .strobe(st_reg.sampStrobe),
        .bitOut(voteBit),
        .bitValid(voteValid)
    );

    // Next-state logic for registers, timer and pins
    always_comb begin
        st_next = st_reg;
        st_next.halfTick = 1'b0;
        st_next.baudTick = 1'b0;
        st_next.sampStrobe = 1'b0;
        st_next.rdData = 8'h00;

        // Pin synchronisers
        st_next.rxMeta = rxPin;
        st_next.rxSync = st_reg.rxMeta;
        st_next.ckMeta = serClkIn;
        st_next.ckSync = st_reg.ckMeta;
        st_next.ckDly = st_reg.ckSync;

        // Register writes, masked to writable bits
        if (regWr) begin
            unique case (regAddr)
                `SBG_ADDR_TXCTL: begin
                    st_next.txCtl = regWrData & `SBG_TXCTL_WMASK;
                end
                `SBG_ADDR_RXCTL: begin
                    st_next.rxCtl = regWrData & `SBG_RXCTL_WMASK;
                end
                `SBG_ADDR_BAUDCTL: begin
                    st_next.baudCtl = regWrData & `SBG_BAUDCTL_WMASK;
                end
                `SBG_ADDR_DIVHI: begin
                    st_next.divHi = regWrData;
                end
                `SBG_ADDR_DIVLO: begin
                    st_next.divLo = regWrData;
                end
                default: begin
                    // Unmapped or read-only offset, write ignored
                end
            endcase
        end

        // Register reads, data stand in the following cycle
        if (regRd) begin
            unique case (regAddr)
                `SBG_ADDR_TXCTL: begin
                    // Shift register always reads empty
                    st_next.rdData = st_reg.txCtl |
                        (8'h01 << `SBG_TX_SHIFT_EMPTY);
                end
                `SBG_ADDR_RXCTL: begin
                    st_next.rdData = st_reg.rxCtl;
                end
                `SBG_ADDR_BAUDCTL: begin
                    // Idle flag follows the voted line level
                    st_next.rdData = st_reg.baudCtl |
                        ({7'h00, voteBit} << `SBG_BC_IDLE);
                end
                `SBG_ADDR_DIVHI: begin
                    st_next.rdData = st_reg.divHi;
                end
                `SBG_ADDR_DIVLO: begin
                    st_next.rdData = st_reg.divLo;
                end
                `SBG_ADDR_STATUS: begin
                    // Live divider state
                    st_next.rdData = {4'h0, voteBit, st_reg.rxSync,
                        st_reg.phase, st_reg.clkLvl};
                end
                default: begin
                    // Unmapped offsets read as zero
                    st_next.rdData = 8'h00;
                end
            endcase
        end

        // Divider timer on the device clock
        if (!enabled) begin
            // Port disabled: everything held at rest
            st_next.pre = 5'h00; // R16
            st_next.cnt = 16'h0000;
            st_next.phase = 1'b0;
            st_next.clkLvl = 1'b0;
            st_next.sampLeft = 2'h0;
        end else if (divWrite) begin
            // New divisor takes effect at once
            st_next.pre = 5'h00; // R13
            st_next.cnt = 16'h0000;
            st_next.phase = 1'b0;
            st_next.clkLvl = 1'b0;
            st_next.sampLeft = 2'h0;
        end else if (syncMode && !master) begin
            // Slave: bit clock comes from the other party
            st_next.pre = 5'h00; // R11
            st_next.cnt = 16'h0000;
            st_next.clkLvl = st_reg.ckSync ^ clkPol;
            if (ckEdge) begin
                st_next.baudTick = 1'b1;
                st_next.sampLeft = `SBG_NUM_SAMPLES;
            end
        end else begin
            // Master or asynchronous: free-running timer
            if (preWrap) begin
                st_next.pre = 5'h00;
                if (cntWrap) begin
                    // Overflow marks half a bit period
                    st_next.cnt = 16'h0000; // R2
                    st_next.halfTick = 1'b1;
                    st_next.phase = !st_reg.phase;
                    st_next.clkLvl = !st_reg.phase;
                    if (st_reg.phase) begin
                        st_next.baudTick = 1'b1;
                    end else begin
                        // Mid-bit: start the majority samples
                        st_next.sampLeft = `SBG_NUM_SAMPLES;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 16'h0001;
                end
            end else begin
                // Counts device clocks, whatever their rate
                st_next.pre = st_reg.pre + 5'h01; // R14
            end
        end

        // Issue the sample strobes on consecutive cycles
        if (st_reg.sampLeft != 2'h0 && enabled && !divWrite) begin
            st_next.sampStrobe = 1'b1; // R15
            st_next.sampLeft = st_reg.sampLeft - 2'h1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{rdData: 8'h00, txCtl: `SBG_RST_TXCTL,
                rxCtl: `SBG_RST_RXCTL, baudCtl: `SBG_RST_BAUDCTL,
                divHi: `SBG_RST_DIV, divLo: `SBG_RST_DIV,
                pre: 5'h00, cnt: 16'h0000, phase: 1'b0,
                clkLvl: 1'b0, halfTick: 1'b0, baudTick: 1'b0,
                rxMeta: 1'b1, rxSync: 1'b1, ckMeta: 1'b0,
                ckSync: 1'b0, ckDly: 1'b0, sampLeft: 2'h0,
                sampStrobe: 1'b0};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign regRdData = st_reg.rdData;
    assign halfTick = st_reg.halfTick;
    assign baudTick = st_reg.baudTick;
    assign rxBit = voteBit;
    assign rxBitValid = voteValid;
    assign portEnable = enabled;
    // Master drives the clock line, idle level set by polarity
    assign serClkOut = st_reg.clkLvl ^ clkPol; // R12
    assign serClkOe = master & enabled; // R12
endmodule

// >>> verif/sbg_baud_gen_assertions.sv
/* Port checker for the serial baud divider.
   Assumes one clock domain and attachment by bind. */
module sbg_baud_gen_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire sbg_pkg::sbg_addr_t regAddr,
    input wire sbg_pkg::sbg_byte_t regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire sbg_pkg::sbg_byte_t regRdData,
    input wire logic serClkOut,
    input wire logic serClkOe,
    input wire logic halfTick,
    input wire logic baudTick,
    input wire logic rxBit,
    input wire logic rxBitValid,
    input wire logic portEnable
);
    import sbg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Steps of a low divisor write and read back
    sequence seqLoWr;
        ce && regWr && regAddr == 3'h4;
    endsequence
    sequence seqLoRd;
        ce && regRd && regAddr == 3'h4;
    endsequence
    // Divisor write while the port runs
    sequence seqDivWr;
        ce && regWr && portEnable && (regAddr == 3'h3 || regAddr == 3'h4);
    endsequence
    a_lo_readback: assert property (
        seqLoWr ##1 seqLoRd |=> regRdData == $past(regWrData, 2))
        else $error("low divisor read back differs");
    a_rd_idle: assert property (
        !$past(regRd) |-> regRdData == 8'h00)
        else $error("read data not zero outside read");
    a_clear_on_write: assert property (
        seqDivWr |=> !halfTick)
        else $error("tick right after divisor write");
    a_tick_single: assert property (
        halfTick |=> !halfTick)
        else $error("half tick longer than one cycle");
    a_baud_on_half: assert property (
        baudTick && serClkOe |-> halfTick)
        else $error("master bit tick without overflow");
    a_clk_toggle: assert property (
        halfTick && serClkOe |-> serClkOut != $past(serClkOut))
        else $error("serial clock did not toggle");
    a_oe_enabled: assert property (
        serClkOe |-> portEnable)
        else $error("clock driven while port disabled");
    a_disabled_quiet: assert property (
        !portEnable && !$past(portEnable) |-> !halfTick && !baudTick)
        else $error("ticks while port disabled");
    a_frozen_ce: assert property (
        !ce |=> $stable(halfTick) && $stable(baudTick) && $stable(rxBit))
        else $error("state moved with clock enable low");
    a_vote_pulse: assert property (
        rxBitValid |=> !rxBitValid)
        else $error("vote valid longer than one cycle");
endmodule

bind sbg_baud_gen sbg_baud_gen_assertions u_chk (.clk(clk),
    .arst_n(arst_n), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .serClkOut(serClkOut), .serClkOe(serClkOe), .halfTick(halfTick),
    .baudTick(baudTick), .rxBit(rxBit), .rxBitValid(rxBitValid),
    .portEnable(portEnable));

// >>> verif/sbg_baud_gen_bench.sv
/* Self-checking bench of the serial baud divider.
   Assumes the design's register map and tick timing of its note. */
module sbg_baud_gen_bench import sbg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, ce, regWr, regRd, rxPin, serClkIn;
    sbg_addr_t regAddr;
    sbg_byte_t regWrData, regRdData, rdVal;
    logic serClkOut, serClkOe, halfTick, baudTick, rxBit, rxBitValid;
    logic portEnable;
    int miscompares = 0, checked = 0, cyc, nTick, expP;
    // Modes as sync, wide, high speed with their division factor
    logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    int facts [7] = '{64, 16, 16, 4, 4, 4, 4};
    // Reset read values; status shows idle voted and synced line high
    sbg_byte_t rstExp [7] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h0C,
        8'h00};

    sbg_baud_gen DUT (.clk(clk), .arst_n(arst_n), .ce(ce),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .rxPin(rxPin),
        .serClkIn(serClkIn), .serClkOut(serClkOut), .serClkOe(serClkOe),
        .halfTick(halfTick), .baudTick(baudTick), .rxBit(rxBit),
        .rxBitValid(rxBitValid), .portEnable(portEnable));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One-cycle register write; hold keeps the strobe up for another
    task automatic wr(input sbg_addr_t a, input sbg_byte_t d,
        input bit hold = 1'b0);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        if (!hold)
            regWr <= 1'b0;
    endtask

    // One-cycle register read; data taken in the following cycle
    task automatic rd(input sbg_addr_t a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        rdVal = regRdData;
        @(posedge clk);
    endtask

    // Selects half tick, bit tick or vote valid
    function automatic logic pick(input int sel);
        return sel == 0 ? halfTick : (sel == 1 ? baudTick : rxBitValid);
    endfunction

    // Cycles up to the next pulse, bounded; sampled at falling edges
    task automatic waitFor(input int sel, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pick(sel) !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            miscompares++;
            complete_run();
        end
        @(posedge clk);
    endtask

    // Pulses seen over a fixed window, sampled where settled
    task automatic countTicks(input int sel, input int len, output int n);
        n = 0;
        repeat (len) begin
            @(negedge clk);
            if (pick(sel) === 1'b1)
                n++;
        end
        @(posedge clk);
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        rxPin = 1'b1;
        serClkIn = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check(portEnable, 1'b0);
        @(posedge clk);
        // Reset values, unmapped offsets read zero
        for (int i = 0; i < 8; i++) begin
            rd(sbg_addr_t'(i));
            check(rdVal, i < 7 ? rstExp[i] : 8'h00);
        end
        // Register access and write masks
        wr(3'h4, 8'h5A);
        rd(3'h4);
        check(rdVal, 8'h5A);
        wr(3'h3, 8'hA5);
        rd(3'h3);
        check(rdVal, 8'hA5);
        wr(3'h1, 8'hFF);
        rd(3'h1);
        check(rdVal, 8'hF8);
        wr(3'h2, 8'hFF);
        rd(3'h2);
        check(rdVal, 8'hDB);
        // Divisor 0x0103: narrow uses 3, wide 259
        wr(3'h3, 8'h01, 1'b1);
        wr(3'h4, 8'h03);
        for (int i = 0; i < 7; i++) begin
            wr(3'h0, {modes[i][2], 2'b00, modes[i][2], 1'b0, modes[i][0],
                2'b00}, 1'b1);
            wr(3'h2, {4'h0, modes[i][1], 3'b000});
            expP = facts[i] * (modes[i][1] ? 260 : 4);
            waitFor(1, cyc);
            waitFor(1, cyc);
            check(cyc, expP);
            waitFor(0, cyc);
            check(cyc, expP / 2);
            @(negedge clk);
            check(serClkOe, modes[i][2]);
            @(posedge clk);
        end
        // Same divisor rewritten mid-count restarts the period
        wr(3'h0, 8'h00, 1'b1);
        wr(3'h2, 8'h00);
        waitFor(0, cyc);
        repeat (50) @(posedge clk);
        wr(3'h4, 8'h03);
        waitFor(0, cyc);
        check(cyc >= 128 && cyc <= 130, 1'b1);
        // Clock enable low stops the timer
        ce <= 1'b0;
        countTicks(0, 300, nTick);
        check(nTick, 0);
        ce <= 1'b1;
        // Receive line held low wins the vote
        rxPin <= 1'b0;
        waitFor(2, cyc);
        waitFor(2, cyc);
        @(negedge clk);
        check(rxBit, 1'b0);
        @(posedge clk);
        rd(3'h2);
        check(rdVal, 8'h00);
        rxPin <= 1'b1;
        // Sync slave: timer idle, ticks follow the outside clock
        wr(3'h0, 8'h10);
        @(negedge clk);
        check(serClkOe, 1'b0);
        @(posedge clk);
        countTicks(0, 200, nTick);
        check(nTick, 0);
        serClkIn <= 1'b1;
        repeat (10) @(posedge clk);
        serClkIn <= 1'b0;
        countTicks(1, 8, nTick);
        check(nTick, 1);
        // Port disabled in master mode: no clock, no ticks
        wr(3'h0, 8'h90, 1'b1);
        wr(3'h1, 8'h00);
        @(negedge clk);
        check({portEnable, serClkOe}, 2'b00);
        @(posedge clk);
        countTicks(0, 300, nTick);
        check(nTick, 0);
        complete_run();
    end
endmodule
